// ==== core/ldo_rail_cfg.svh ====
/*
  Holds: addresses, reset values, field positions and state codes of the
  rail control registers.
  Assumes: included by bare name; only definitions live here.
*/
`ifndef LDO_RAIL_CFG_SVH
`define LDO_RAIL_CFG_SVH

// =====================================================================
// register map
`define AON_CTRL_ADDR   8'h45
`define MEM_CTRL_ADDR   8'h47
`define AON_CTRL_RST    8'h07
`define MEM_CTRL_RST    8'h24

// =====================================================================
// field layout
`define LIVE_MSB        2
`define LIVE_LSB        0
`define EXIT_MSB        5
`define EXIT_LSB        3
`define RSVD_MSB        7
`define RSVD_LSB        6

// =====================================================================
// state codes
`define CODE_OFF        3'h4
`define CODE_LOW        3'h5
`define CODE_ACTIVE     3'h6
`define CODE_VALID_BIT  2

`endif

// ==== core/ldo_rail_pkg.sv ====
/*
  Holds: types and decode functions shared by the rail control logic.
  Assumes: ldo_rail_cfg.svh is on the include path.
*/
`include "ldo_rail_cfg.svh"

package ldo_rail_pkg;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_LOW    = 2'h1,
    MODE_ACTIVE = 2'h3
  } rail_mode_t;

  typedef struct packed {
    logic [2:0] exit_state;
    logic [2:0] live_state;
  } rail_ctrl_t;

  typedef struct packed {
    logic active;
    logic low_power;
    logic discharge;
  } rail_status_t;

  // reserved codes 0..3 never reach the live field, read as off
  function automatic rail_mode_t mode_of(input logic [2:0] code);
    rail_mode_t m;
    m = MODE_OFF;
    case (code)
      `CODE_LOW:   m = MODE_LOW;
      3'h6, 3'h7:  m = MODE_ACTIVE;
      default:     m = MODE_OFF;
    endcase
    return m;
  endfunction

  function automatic rail_status_t status_of(input logic [2:0] code);
    rail_status_t s;
    s.active    = (mode_of(code) == MODE_ACTIVE);
    s.low_power = (mode_of(code) == MODE_LOW);
    s.discharge = (code == `CODE_OFF);
    return s;
  endfunction

  // codes 4..7 name a target, 0..3 mean leave unchanged
  function automatic logic is_target(input logic [2:0] code);
    return code[`CODE_VALID_BIT];
  endfunction

endpackage

// ==== core/rail_ctrl_reg.sv ====
/*
  Holds: one rail's 8-bit control register with live and exit fields,
  and the registered rail status decoded from the live field.
  Assumes: exit_pulse is a one-cycle pulse already in the ref_clk domain.
*/
`include "ldo_rail_cfg.svh"

module rail_ctrl_reg
  import ldo_rail_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h07
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic         wr_en,
  input  wire logic [7:0]   wdata,
  input  wire logic         exit_pulse,
  output rail_ctrl_t        ctrl_q,
  output rail_status_t      status_q
);

  logic [2:0]          exit_q;
  logic [2:0]          live_q;

  // fields kept apart so each has exactly one writing process
  assign ctrl_q = '{exit_state: exit_q, live_state: live_q};

  // =====================================================================
  // exit field: plain read-write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      exit_q <= RST_VAL[`EXIT_MSB:`EXIT_LSB];
    end else if (wr_en) begin
      exit_q <= wdata[`EXIT_MSB:`EXIT_LSB];
    end
  end

  // =====================================================================
  // live field: exit copy wins over a same-cycle write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      live_q <= RST_VAL[`LIVE_MSB:`LIVE_LSB];
    end else if (exit_pulse && is_target(exit_q)) begin
      live_q <= exit_q;
    end else if (wr_en && is_target(wdata[`LIVE_MSB:`LIVE_LSB])) begin
      live_q <= wdata[`LIVE_MSB:`LIVE_LSB];
    end
  end

  // =====================================================================
  // decoded rail drive, one cycle behind the live field
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_q <= status_of(RST_VAL[`LIVE_MSB:`LIVE_LSB]);
    end else begin
      status_q <= status_of(live_q);
    end
  end

endmodule

// ==== core/ldo_rail_state_control.sv ====
/*
  Holds: state control of the always-on and memory rails, discharge of
  the memory and core rails, and over-current / under-voltage events.
  Assumes: the serial host front end delivers decoded register accesses
  on ref_clk; standby exit and supervisor comparators are asynchronous
  pins; the core rail live state comes from ref_clk logic elsewhere.
*/
`include "ldo_rail_cfg.svh"

module ldo_rail_state_control
  import ldo_rail_pkg::*;
#(
  parameter int NUM_SUP = 3
) (
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 standby_exit_pin,
  input  wire logic [2:0]           core_rail_live_state,
  input  wire logic [NUM_SUP-1:0]   oc_raw,
  input  wire logic [NUM_SUP-1:0]   uv_raw,
  output rail_status_t              always_on_rail_status,
  output rail_status_t              memory_rail_status,
  output logic                      core_rail_discharge,
  output logic      [NUM_SUP-1:0]   oc_event,
  output logic      [NUM_SUP-1:0]   uv_event
);

  rail_ctrl_t          aon_ctrl;
  rail_ctrl_t          mem_ctrl;
  logic                exit_s1_q;
  logic                exit_s2_q;
  logic                exit_s3_q;
  logic                exit_pulse;
  logic                wr_aon;
  logic                wr_mem;
  logic [NUM_SUP-1:0]  oc_s1_q;
  logic [NUM_SUP-1:0]  oc_s2_q;
  logic [NUM_SUP-1:0]  oc_s3_q;
  logic [NUM_SUP-1:0]  uv_s1_q;
  logic [NUM_SUP-1:0]  uv_s2_q;
  logic [NUM_SUP-1:0]  uv_s3_q;
  logic [7:0]          rdata_d;

  function automatic logic [7:0] pack_reg(input rail_ctrl_t c);
    return {2'b00, c.exit_state, c.live_state};
  endfunction

  // =====================================================================
  // standby exit pin: synchroniser and rising-edge pulse
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      exit_s1_q <= 1'b0;
      exit_s2_q <= 1'b0;
      exit_s3_q <= 1'b0;
    end else begin
      exit_s1_q <= standby_exit_pin;
      exit_s2_q <= exit_s1_q;
      exit_s3_q <= exit_s2_q;
    end
  end

  assign exit_pulse = exit_s2_q & ~exit_s3_q;

  // =====================================================================
  // register write decode, one strobe per rail
  assign wr_aon = reg_wr && (reg_addr == `AON_CTRL_ADDR);
  assign wr_mem = reg_wr && (reg_addr == `MEM_CTRL_ADDR);

  rail_ctrl_reg #(
    .RST_VAL    (`AON_CTRL_RST)
  ) u_aon_reg (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .wr_en      (wr_aon),
    .wdata      (reg_wdata),
    .exit_pulse (exit_pulse),
    .ctrl_q     (aon_ctrl),
    .status_q   (always_on_rail_status)
  );

  rail_ctrl_reg #(
    .RST_VAL    (`MEM_CTRL_RST)
  ) u_mem_reg (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .wr_en      (wr_mem),
    .wdata      (reg_wdata),
    .exit_pulse (exit_pulse),
    .ctrl_q     (mem_ctrl),
    .status_q   (memory_rail_status)
  );

  // =====================================================================
  // register read, data registered, unmapped reads as zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `AON_CTRL_ADDR: rdata_d = pack_reg(aon_ctrl);
      `MEM_CTRL_ADDR: rdata_d = pack_reg(mem_ctrl);
      default:        rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rdata_d : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // =====================================================================
  // core rail discharge while its live state is off
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_rail_discharge <= 1'b0;
    end else begin
      core_rail_discharge <= (core_rail_live_state == `CODE_OFF);
    end
  end

  // =====================================================================
  // supervisor inputs: synchronise, pulse on each new condition
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oc_s1_q  <= '0;
      oc_s2_q  <= '0;
      oc_s3_q  <= '0;
      oc_event <= '0;
    end else begin
      oc_s1_q  <= oc_raw;
      oc_s2_q  <= oc_s1_q;
      oc_s3_q  <= oc_s2_q;
      oc_event <= oc_s2_q & ~oc_s3_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      uv_s1_q  <= '0;
      uv_s2_q  <= '0;
      uv_s3_q  <= '0;
      uv_event <= '0;
    end else begin
      uv_s1_q  <= uv_raw;
      uv_s2_q  <= uv_s1_q;
      uv_s3_q  <= uv_s2_q;
      uv_event <= uv_s2_q & ~uv_s3_q;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  aon_reset_val_a: assert property ($fell(srst) |-> pack_reg(aon_ctrl) == `AON_CTRL_RST)
    else $error("always-on register reset value wrong");

  mem_reset_val_a: assert property ($fell(srst) |-> pack_reg(mem_ctrl) == `MEM_CTRL_RST)
    else $error("memory register reset value wrong");

  aon_read_back_a: assert property (
    reg_rd && reg_addr == `AON_CTRL_ADDR |=> reg_rvalid && reg_rdata == $past(pack_reg(aon_ctrl)))
    else $error("always-on register read data wrong");

  rsvd_read_zero_a: assert property (reg_rvalid |-> reg_rdata[`RSVD_MSB:`RSVD_LSB] == 2'b00)
    else $error("reserved bits read nonzero");

  exit_copy_a: assert property (
    exit_pulse && is_target(mem_ctrl.exit_state) |=> mem_ctrl.live_state == $past(mem_ctrl.exit_state))
    else $error("standby exit did not copy exit field");

  exit_keep_a: assert property (
    exit_pulse && !is_target(aon_ctrl.exit_state) && !wr_aon |=> $stable(aon_ctrl.live_state))
    else $error("leave-unchanged exit code altered live state");

  exit_latency_a: assert property (
    $rose(standby_exit_pin) ##1 standby_exit_pin ##1 standby_exit_pin |-> exit_pulse)
    else $error("standby exit pulse not two cycles after pin");

  rsvd_live_keep_a: assert property (
    wr_aon && !is_target(reg_wdata[`LIVE_MSB:`LIVE_LSB]) && !exit_pulse |=> $stable(aon_ctrl.live_state))
    else $error("reserved live code changed the rail");

  rail_isolate_a: assert property (wr_mem && !exit_pulse |=> $stable(aon_ctrl))
    else $error("memory write disturbed always-on rail");

  // reset edge itself excluded: the flops still take reset values there
  live_decode_a: assert property (
    !srst |=> always_on_rail_status.active == ($past(aon_ctrl.live_state) >= `CODE_ACTIVE)
      && always_on_rail_status.low_power == ($past(aon_ctrl.live_state) == `CODE_LOW))
    else $error("live state decode wrong");

  mem_discharge_a: assert property (
    mem_ctrl.live_state == `CODE_OFF ##1 mem_ctrl.live_state == `CODE_OFF |-> memory_rail_status.discharge)
    else $error("memory rail off without discharge");

  core_discharge_a: assert property (
    !srst |=> core_rail_discharge == ($past(core_rail_live_state) == `CODE_OFF))
    else $error("core rail discharge mismatch");

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SUP; gi++) begin : g_sup_chk
      oc_event_src_a: assert property (oc_event[gi] |-> $past(oc_raw[gi], 3))
        else $error("over-current event without cause");
      uv_event_src_a: assert property (uv_event[gi] |-> $past(uv_raw[gi], 3))
        else $error("under-voltage event without cause");
      uv_event_one_a: assert property (uv_event[gi] |=> !uv_event[gi])
        else $error("under-voltage event longer than one cycle");
    end
  endgenerate

  exit_to_active_c: cover property (exit_pulse && aon_ctrl.exit_state >= `CODE_ACTIVE);
  mem_turn_off_c:   cover property (wr_mem && reg_wdata[`LIVE_MSB:`LIVE_LSB] == `CODE_OFF);
  oc_raise_c:       cover property (|oc_event);
  write_on_exit_c:  cover property (exit_pulse && wr_aon);

endmodule

// ==== bench/rail_host_model.sv ====
/*
  Holds: behavioural model of the host front end issuing decoded
  register writes and reads on the rail control register port.
  Assumes: driven from the bench through its tasks, one access at a time.
*/
module rail_host_model (
  input  wire logic       ref_clk,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // =====================================================================
  // accesses
  // exit fields are set through here before any standby exit
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // no valid strobe gives unknown data
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule

// ==== bench/tb_ldo_rail_state_control.sv ====
/*
  Holds: self-checking bench for the rail state control block.
  Assumes: rail_host_model drives the register port; 40 MHz clock.
*/
module tb_ldo_rail_state_control;
  import ldo_rail_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic         ref_clk = 1'b0;
  logic         srst = 1'b1;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata;
  logic         reg_wr, reg_rd, reg_rvalid;
  logic         standby_exit_pin = 1'b0;
  logic [2:0]   core_rail_live_state = 3'h4;
  logic [2:0]   oc_raw = 3'h0;
  logic [2:0]   uv_raw = 3'h0;
  rail_status_t always_on_rail_status, memory_rail_status;
  logic         core_rail_discharge;
  logic [2:0]   oc_event, uv_event;
  logic [7:0]   d;
  logic [7:0]   st_exp [4] = '{8'h01, 8'h02, 8'h04, 8'h04};
  int           errors = 0;
  int           n_tests = 0;
  int           hits;

  always #12.5 ref_clk = ~ref_clk;

  rail_host_model rail_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  ldo_rail_state_control #(.NUM_SUP(3)) ldo_rail_state_control_i (.ref_clk(ref_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .standby_exit_pin(standby_exit_pin),
    .core_rail_live_state(core_rail_live_state), .oc_raw(oc_raw), .uv_raw(uv_raw),
    .always_on_rail_status(always_on_rail_status), .memory_rail_status(memory_rail_status),
    .core_rail_discharge(core_rail_discharge), .oc_event(oc_event), .uv_event(uv_event));

  // =====================================================================
  // checking and closing
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // pin high four edges, then low long enough to re-arm
  task automatic pulse_exit();
    @(posedge ref_clk);
    standby_exit_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    standby_exit_pin <= 1'b0;
    cyc(4);
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end

  // =====================================================================
  // tests
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rail_host_model_i.rd(8'h45, d);
    chk("aon_reset", 8'h07, d);
    rail_host_model_i.rd(8'h47, d);
    chk("mem_reset", 8'h24, d);
    chk("mem_discharge", 8'h01, 8'(memory_rail_status));
    rail_host_model_i.rd(8'h46, d);
    chk("unmapped", 8'h00, d);
    for (int c = 4; c < 8; c++) begin
      rail_host_model_i.wr(8'h45, 8'(c));
      cyc(2);
      chk("aon_status", st_exp[c-4], 8'(always_on_rail_status));
      chk("mem_untouched", 8'h01, 8'(memory_rail_status));
    end
    rail_host_model_i.wr(8'h47, 8'hed);
    rail_host_model_i.rd(8'h47, d);
    chk("rsvd_bits", 8'h2d, d);
    chk("mem_low", 8'h02, 8'(memory_rail_status));
    chk("aon_kept", 8'h04, 8'(always_on_rail_status));
    rail_host_model_i.wr(8'h47, 8'h01);
    rail_host_model_i.rd(8'h47, d);
    chk("rsvd_live", 8'h05, d);
    rail_host_model_i.wr(8'h45, 8'h27);
    pulse_exit();
    rail_host_model_i.rd(8'h45, d);
    chk("aon_exit", 8'h24, d);
    chk("aon_exit_off", 8'h01, 8'(always_on_rail_status));
    rail_host_model_i.rd(8'h47, d);
    chk("mem_no_copy", 8'h05, d);
    rail_host_model_i.wr(8'h45, 8'h02);
    rail_host_model_i.wr(8'h47, 8'h35);
    rail_host_model_i.rd(8'h45, d);
    chk("aon_rsvd_live", 8'h04, d);
    pulse_exit();
    rail_host_model_i.rd(8'h47, d);
    chk("mem_exit", 8'h36, d);
    chk("mem_exit_on", 8'h04, 8'(memory_rail_status));
    rail_host_model_i.rd(8'h45, d);
    chk("aon_no_copy", 8'h04, d);
    chk("aon_still_off", 8'h01, 8'(always_on_rail_status));
    @(posedge ref_clk);
    core_rail_live_state <= 3'h6;
    cyc(2);
    chk("core_on", 8'h00, 8'(core_rail_discharge));
    @(posedge ref_clk);
    core_rail_live_state <= 3'h4;
    cyc(2);
    chk("core_off", 8'h01, 8'(core_rail_discharge));
    for (int k = 0; k < 2; k++) begin
      hits = 0;
      @(posedge ref_clk);
      oc_raw <= (k == 0) ? 3'b010 : 3'b000;
      uv_raw <= (k == 1) ? 3'b100 : 3'b000;
      for (int t = 0; t < 8; t++) begin
        cyc(1);
        if ({oc_event, uv_event} === {oc_raw, uv_raw})
          hits++;
        else if ({oc_event, uv_event} !== 6'h00)
          hits += 10;
      end
      chk("event_pulse", 8'h01, 8'(hits));
      @(posedge ref_clk);
      oc_raw <= 3'b000;
      uv_raw <= 3'b000;
      cyc(4);
    end
    end_of_test();
  end
endmodule
